// ===== acr_check.sv
// ----------------------------------------------------------------
// setting checker: validity of the combination and pixel depth
// ----------------------------------------------------------------
module acr_check
    import acr_pkg::*;
#(
    parameter logic [2:0] MODE_MAX    = 3'h5,  // highest mode accepted
    parameter logic [2:0] RATE_MAX    = 3'h5,  // highest frame-rate code accepted
    parameter logic [1:0] SPEED_MAX   = 2'h2,  // highest transmit speed code
    parameter logic [2:0] MONO16_MODE = 3'h1   // standard mode giving 16-bit mono
) (
    input  wire logic [2:0] fmt,          // current format code
    input  wire logic [2:0] mode,         // current mode code
    input  wire logic [2:0] rate,         // current frame-rate code
    input  wire logic [1:0] speed,        // current transmit speed code
    input  wire logic [7:0] coding,       // pixel_coding_selector
    output logic            fmt_ok,       // format accepts frame controls
    output logic            invalid,      // combination not acceptable
    output logic [7:0]      depth         // effective bits per pixel
);

    // ----------------------------------------------------------------
    // combinational decode
    // ----------------------------------------------------------------
    always_comb begin
        fmt_ok  = (fmt <= FMT_STD_MAX) || (fmt == FMT_SCALABLE);          // R3
        // the scalable format never raises the flag; other formats are
        // judged on mode, rate and speed but not coding, unsupported formats always fail
        if (fmt == FMT_SCALABLE) begin                                    // R7
            invalid = 1'b0;
        end else begin
            invalid = (fmt > FMT_STD_MAX) || (mode > MODE_MAX)
                   || (rate > RATE_MAX) || (speed > SPEED_MAX);
        end
        // depth follows coding in the scalable format, mode otherwise
        if (fmt == FMT_SCALABLE) begin                                    // R10
            depth = (coding == CODING_MONO16) ? DEPTH_MONO16 : DEPTH_MONO8; // R11
        end else begin
            depth = (mode == MONO16_MODE) ? DEPTH_MONO16 : DEPTH_MONO8;   // R11
        end
    end

endmodule

// ===== acr_host.sv
// ----------------------------------------------------------------
// host model: issues strobe-port register cycles, one per call
// ----------------------------------------------------------------
module acr_host (
    input  wire logic        clk,    // core clock
    output logic      [11:0] addr,   // register byte offset
    output logic             wr,     // write strobe, one cycle
    output logic             rd,     // read strobe, one cycle
    output logic      [31:0] wdata,  // write quadlet
    input  wire logic [31:0] rdata,  // read quadlet
    input  wire logic        rack    // read answer pulse
);
    timeunit 1ns;
    timeprecision 1ns;

    // bus idle from time zero
    initial begin
        addr  = 12'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
        wdata = 32'h0000_0000;
    end

    // write: strobe stands one cycle, so the device takes it once
    task automatic put(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d; // stale data must not look valid
    endtask

    // read: the answer must stand exactly one edge after the strobe is
    // taken; a late or missing answer returns x and fails the compare
    task automatic get(input logic [11:0] a, output logic [31:0] d);
        d = 'x;
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        if (rack === 1'b1) begin
            d = rdata;
        end
    endtask
endmodule

// ===== acr_pkg.sv
package acr_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses from the register base)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_CONT  = 12'h0614; // continuous_transmit_control
    localparam logic [11:0] OFS_SHOT  = 12'h061C; // single_frame_control
    localparam logic [11:0] OFS_VALID = 12'h0628; // config_validity_status
    localparam logic [11:0] OFS_TRIG  = 12'h062C; // soft_trigger_control
    localparam logic [11:0] OFS_DEPTH = 12'h0630; // effective_pixel_depth

    // ----------------------------------------------------------------
    // field positions: quadlet bit 0 is the most significant bit
    // ----------------------------------------------------------------
    localparam int POS_BIT0      = 31;           // bit 0 of every register
    localparam int POS_MULTI     = 30;           // repeated-frame request bit 1
    localparam int POS_DEPTH_LSB = 24;           // depth field, bits 0..7
    localparam int DEPTH_W       = 8;            // depth field width

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic       RST_CONT   = 1'b0;    // continuous bit
    localparam logic       RST_TRIG   = 1'b0;    // software trigger bit
    localparam logic       RST_INVAL  = 1'b0;    // validity flag
    localparam logic [2:0] FMT_DEFAULT = 3'h7;   // scalable format after reset
    localparam logic [7:0] RST_DEPTH  = 8'h08;   // depth until first update

    // ----------------------------------------------------------------
    // format, coding and depth encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] FMT_STD_MAX  = 3'h2;  // formats 0..2 are supported
    localparam logic [2:0] FMT_SCALABLE = 3'h7;  // scalable format code
    localparam logic [7:0] CODING_MONO8  = 8'h00; // pixel coding: mono 8
    localparam logic [7:0] CODING_MONO16 = 8'h05; // pixel coding: mono 16
    localparam logic [7:0] DEPTH_MONO8  = 8'h08; // 8 bits per pixel
    localparam logic [7:0] DEPTH_MONO16 = 8'h0A; // 10 bits per pixel
    localparam logic [3:0] TRIG_MODE_SELFCLR = 4'h0; // mode that self-clears

    // single-frame sequencer states
    typedef enum logic [1:0] {
        ACR_SHOT_IDLE = 2'b00,                   // no frame requested
        ACR_SHOT_SEND = 2'b01                    // one frame in flight
    } acr_shot_t;

endpackage

// ===== acr_regs.sv
// Summary of operation
// R1: bit 0 at 0x614 starts/stops continuous transmission
// R2: single-frame bit sends one frame, then self-clears
// R3: single-frame works only in formats 0-2, 7
// R4: repeated-frame bit and count field are ignored
// R5: validity flag recomputed when any setting changes
// R6: flag 0 allows capture, 1 blocks capture start
// R7: validity flag read-only, meaningless in format 7
// R8: host sets/clears software trigger; device acts on it
// R9: trigger mode 0 makes trigger bit self-clear
// R10: read-only depth field from format, mode, coding
// R11: depth reads 8 for mono8, 10 for mono16
// R12: format code 3 bits, default 7 scalable
// R13: msb-first quadlets, reserved bits read 0
module acr_regs
    import acr_pkg::*;
#(
    parameter logic [2:0] MODE_MAX    = 3'h5,  // highest mode accepted
    parameter logic [2:0] RATE_MAX    = 3'h5,  // highest frame-rate code accepted
    parameter logic [1:0] SPEED_MAX   = 2'h2,  // highest transmit speed code
    parameter logic [2:0] MONO16_MODE = 3'h1   // standard mode giving 16-bit mono
) (
    input  wire logic        CORE_CLK,     // 20 MHz core clock
    input  wire logic        NRST,         // asynchronous reset, active low
    input  wire logic [11:0] REG_ADDR,     // register byte offset
    input  wire logic        REG_WR,       // write strobe, one cycle
    input  wire logic        REG_RD,       // read strobe, one cycle
    input  wire logic [31:0] REG_WDATA,    // write quadlet
    output logic      [31:0] REG_RDATA,    // read quadlet
    output logic             REG_RACK,     // read data valid, one cycle
    input  wire logic [2:0]  FMT_SEL,      // current format code
    input  wire logic [2:0]  MODE_SEL,     // current mode code
    input  wire logic [2:0]  RATE_SEL,     // current frame-rate code
    input  wire logic [1:0]  SPEED_SEL,    // current transmit speed code
    input  wire logic [7:0]  CODING_SEL,   // pixel_coding_selector
    input  wire logic        TRIG_SRC_SW,  // trigger source is software
    input  wire logic [3:0]  TRIG_MODE,    // trigger mode field
    input  wire logic        FRAME_DONE,   // pulse: a frame has been sent
    output logic             CONT_EN,      // continuous transmission running
    output logic             SHOT_REQ,     // single frame requested
    output logic             SW_TRIG,      // software trigger level
    output logic             CFG_INVALID,  // config_invalid_flag
    output logic [7:0]       PIXEL_DEPTH   // effective bits per pixel
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [2:0] fmt_q;          // registered format copy
    logic [2:0] mode_q;         // registered mode copy
    logic [2:0] rate_q;         // registered frame-rate copy
    logic [1:0] speed_q;        // registered speed copy
    logic [7:0] coding_q;       // registered coding copy
    logic       chg;            // some setting differs from the copy
    logic       chk_ok;         // new format accepts frame controls
    logic       chk_invalid;    // new combination rejected
    logic [7:0] chk_depth;      // new pixel depth
    logic       fmt_ok_q;       // current format accepts frame controls
    logic       cont_q;         // continuous bit as stored
    logic       trig_q;         // software trigger bit
    logic       inval_q;        // validity flag
    logic [7:0] depth_q;        // depth field
    logic       wr_cont;        // write to continuous register
    logic       wr_shot;        // write to single-frame register
    logic       wr_trig;        // write to trigger register
    logic       shot_go;        // accepted single-frame start
    logic       wbit0;          // bit 0 of the write quadlet
    acr_shot_t  shot_q;         // single-frame state
    acr_shot_t  shot_d;         // next single-frame state
    logic       cont_run_q;     // gated continuous output
    logic [31:0] rdata_d;       // read mux

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (SPEED_MAX > 2'h2) begin : g_bad_speed
        $error("speed codes above 2 are not served");
    end

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    assign wbit0   = REG_WDATA[POS_BIT0];                                  // R13
    assign wr_cont = REG_WR && (REG_ADDR == OFS_CONT);
    assign wr_shot = REG_WR && (REG_ADDR == OFS_SHOT);
    assign wr_trig = REG_WR && (REG_ADDR == OFS_TRIG) && TRIG_SRC_SW;     // R8
    // a start is refused while the combination is bad or the format is
    // not one that takes frame controls
    assign shot_go = wr_shot && wbit0 && fmt_ok_q && !(inval_q);          // R3 R6

    // ----------------------------------------------------------------
    // setting checker
    // ----------------------------------------------------------------
    acr_check #(
        .MODE_MAX    (MODE_MAX),
        .RATE_MAX    (RATE_MAX),
        .SPEED_MAX   (SPEED_MAX),
        .MONO16_MODE (MONO16_MODE)
    ) u_check (
        .fmt     (FMT_SEL),
        .mode    (MODE_SEL),
        .rate    (RATE_SEL),
        .speed   (SPEED_SEL),
        .coding  (CODING_SEL),
        .fmt_ok  (chk_ok),
        .invalid (chk_invalid),
        .depth   (chk_depth)
    );

    assign chg = (FMT_SEL != fmt_q) || (MODE_SEL != mode_q) || (RATE_SEL != rate_q)
              || (SPEED_SEL != speed_q) || (CODING_SEL != coding_q);

    // ----------------------------------------------------------------
    // setting copies; format starts at the scalable default
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            fmt_q    <= FMT_DEFAULT;                                       // R12
            mode_q   <= 3'h0;
            rate_q   <= 3'h0;
            speed_q  <= 2'h0;
            coding_q <= CODING_MONO8;
        end else begin
            fmt_q    <= FMT_SEL;
            mode_q   <= MODE_SEL;
            rate_q   <= RATE_SEL;
            speed_q  <= SPEED_SEL;
            coding_q <= CODING_SEL;
        end
    end

    // ----------------------------------------------------------------
    // status recomputed on every change of a setting
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            inval_q  <= RST_INVAL;
            depth_q  <= RST_DEPTH;
            fmt_ok_q <= 1'b1;          // default format 7 accepts controls
        end else if (chg) begin
            inval_q  <= chk_invalid;                                       // R5
            depth_q  <= chk_depth;                                         // R10
            fmt_ok_q <= chk_ok;
        end
    end

    // ----------------------------------------------------------------
    // continuous transmission bit and its gated output
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            cont_q <= RST_CONT;
        end else if (wr_cont) begin
            cont_q <= wbit0;                                               // R1
        end
    end

    // the stored bit stays as written; running stops while blocked
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            cont_run_q <= 1'b0;
        end else begin
            cont_run_q <= cont_q && fmt_ok_q && !inval_q;                  // R1 R6
        end
    end

    // ----------------------------------------------------------------
    // single-frame sequencer; bits 1 and 16..31 are never looked at
    // ----------------------------------------------------------------
    always_comb begin
        shot_d = shot_q;
        case (shot_q)
            ACR_SHOT_IDLE: begin
                if (shot_go) begin                                         // R2 R4
                    shot_d = ACR_SHOT_SEND;
                end
            end
            ACR_SHOT_SEND: begin
                // a new request in the done cycle wins over the clear
                if (FRAME_DONE && !shot_go) begin                          // R2
                    shot_d = ACR_SHOT_IDLE;
                end
            end
            default: shot_d = ACR_SHOT_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            shot_q <= ACR_SHOT_IDLE;
        end else begin
            shot_q <= shot_d;
        end
    end

    // ----------------------------------------------------------------
    // software trigger bit
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            trig_q <= RST_TRIG;
        end else if (wr_trig) begin
            trig_q <= wbit0;                                               // R8
        end else if (trig_q && (TRIG_MODE == TRIG_MODE_SELFCLR)) begin
            trig_q <= 1'b0;                                                // R9
        end
    end

    // ----------------------------------------------------------------
    // read mux; reserved bits and unmapped offsets read zero
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;                                           // R13
        case (REG_ADDR)
            OFS_CONT:  rdata_d[POS_BIT0] = cont_q;
            OFS_SHOT:  rdata_d[POS_BIT0] = shot_q[0];
            OFS_VALID: rdata_d[POS_BIT0] = inval_q;                        // R7
            OFS_TRIG:  rdata_d[POS_BIT0] = trig_q;
            OFS_DEPTH: rdata_d[POS_DEPTH_LSB +: DEPTH_W] = depth_q;        // R10
            default:   rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            REG_RDATA <= 32'h0000_0000;
            REG_RACK  <= 1'b0;
        end else begin
            REG_RACK  <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rdata_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs straight from flip-flops
    // ----------------------------------------------------------------
    assign CONT_EN     = cont_run_q;
    assign SHOT_REQ    = shot_q[0];
    assign SW_TRIG     = trig_q;
    assign CFG_INVALID = inval_q;
    assign PIXEL_DEPTH = depth_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    property p_cont_stop;
        wr_cont && !wbit0 |=> !cont_q ##1 !CONT_EN;
    endproperty
    a_cont_stop: assert property (p_cont_stop) else $error("continuous not stopped"); // R1
    property p_shot_start;
        (shot_q == ACR_SHOT_IDLE) && shot_go |=> SHOT_REQ;
    endproperty
    a_shot_start: assert property (p_shot_start) else $error("single frame not started"); // R2
    property p_shot_hold;
        SHOT_REQ && !FRAME_DONE |=> SHOT_REQ;
    endproperty
    a_shot_hold: assert property (p_shot_hold) else $error("single frame dropped early"); // R2
    property p_shot_clear;
        SHOT_REQ && FRAME_DONE && !wr_shot |=> !SHOT_REQ;
    endproperty
    a_shot_clear: assert property (p_shot_clear) else $error("single frame not cleared"); // R2
    property p_shot_fmt;
        !SHOT_REQ && wr_shot && !fmt_ok_q |=> !SHOT_REQ;
    endproperty
    a_shot_fmt: assert property (p_shot_fmt) else $error("single frame in wrong format"); // R3
    property p_multi_ignored;
        !SHOT_REQ && wr_shot && !wbit0 |=> !SHOT_REQ;
    endproperty
    a_multi_ignored: assert property (p_multi_ignored) else $error("upper bits started a frame"); // R4
    property p_recompute;
        chg |=> CFG_INVALID == $past(chk_invalid) && PIXEL_DEPTH == $past(chk_depth);
    endproperty
    a_recompute: assert property (p_recompute) else $error("status not recomputed"); // R5
    property p_block;
        CFG_INVALID |=> !CONT_EN;
    endproperty
    a_block: assert property (p_block) else $error("capture ran while invalid"); // R6
    property p_fmt7_valid;
        fmt_q == FMT_SCALABLE && !chg |-> !CFG_INVALID;
    endproperty
    a_fmt7_valid: assert property (p_fmt7_valid) else $error("flag set in scalable format"); // R7
    property p_trig_self;
        SW_TRIG && TRIG_MODE == TRIG_MODE_SELFCLR && !wr_trig |=> !SW_TRIG;
    endproperty
    a_trig_self: assert property (p_trig_self) else $error("trigger did not self clear"); // R9
    property p_depth_read;
        REG_RD && REG_ADDR == OFS_DEPTH |=>
            REG_RACK && REG_RDATA[POS_DEPTH_LSB +: DEPTH_W] == $past(depth_q)
            && REG_RDATA[POS_DEPTH_LSB-1:0] == 24'h00_0000;
    endproperty
    a_depth_read: assert property (p_depth_read) else $error("depth read wrong"); // R10

endmodule

// ===== acr_regs_test.sv
// ----------------------------------------------------------------
// self-checking bench for the acquisition control registers
// ----------------------------------------------------------------
module acr_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import acr_pkg::*;

    typedef struct packed {
        logic [2:0] f;    // format
        logic [2:0] m;    // mode
        logic [2:0] r;    // frame rate
        logic [1:0] s;    // speed
        logic [7:0] c;    // pixel coding
        logic       bad;  // expected flag
        logic [7:0] dep;  // expected depth
    } acr_row_t;

    logic        clk       = 1'b0;     // 20 MHz core clock
    logic        nrst_n    = 1'b0;     // reset, active low
    logic [11:0] reg_addr;             // host offset
    logic        reg_wr;               // host write strobe
    logic        reg_rd;               // host read strobe
    logic [31:0] reg_wdata;            // host write data
    logic [31:0] reg_rdata;            // read data
    logic        reg_rack;             // read answer
    logic [2:0]  fmt       = 3'h7;     // reset-time defaults
    logic [2:0]  mode      = 3'h0;
    logic [2:0]  rate      = 3'h0;
    logic [1:0]  speed     = 2'h0;
    logic [7:0]  coding    = 8'h00;
    logic        src_sw    = 1'b0;     // trigger source software
    logic [3:0]  tmode     = 4'h0;     // trigger mode
    logic        frame_done = 1'b0;    // frame sent pulse
    logic        cont_en, shot_req, sw_trig, cfg_invalid;
    logic [7:0]  depth;
    int          failures    = 0;
    int          check_count = 0;
    // settings sweep: codes past the limits and format 7 overrides
    acr_row_t    rows [8] = '{
        '{3'h0, 3'h0, 3'h0, 2'h0, 8'h00, 1'b0, 8'h08},
        '{3'h0, 3'h1, 3'h0, 2'h0, 8'h00, 1'b0, 8'h0A},
        '{3'h1, 3'h6, 3'h0, 2'h0, 8'h00, 1'b1, 8'h08},
        '{3'h2, 3'h0, 3'h6, 2'h0, 8'h00, 1'b1, 8'h08},
        '{3'h0, 3'h0, 3'h0, 2'h3, 8'h00, 1'b1, 8'h08},
        '{3'h3, 3'h0, 3'h0, 2'h0, 8'h00, 1'b1, 8'h08},
        '{3'h7, 3'h6, 3'h6, 2'h3, 8'h05, 1'b0, 8'h0A},
        '{3'h0, 3'h0, 3'h0, 2'h0, 8'h00, 1'b0, 8'h08}};

    always #25 clk = ~clk;

    acr_host host (.clk(clk), .addr(reg_addr), .wr(reg_wr), .rd(reg_rd),
                   .wdata(reg_wdata), .rdata(reg_rdata), .rack(reg_rack));

    acr_regs dut (.CORE_CLK(clk), .NRST(nrst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
                  .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
                  .REG_RACK(reg_rack), .FMT_SEL(fmt), .MODE_SEL(mode), .RATE_SEL(rate),
                  .SPEED_SEL(speed), .CODING_SEL(coding), .TRIG_SRC_SW(src_sw),
                  .TRIG_MODE(tmode), .FRAME_DONE(frame_done), .CONT_EN(cont_en),
                  .SHOT_REQ(shot_req), .SW_TRIG(sw_trig), .CFG_INVALID(cfg_invalid),
                  .PIXEL_DEPTH(depth));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        host.get(a, d);
        chk(d, exp, "read data");
    endtask

    // let edges land, then look just after the last one
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // settings change as one step; status gets time to follow
    task automatic set_cfg(input acr_row_t w);
        @(posedge clk);
        fmt    <= w.f;
        mode   <= w.m;
        rate   <= w.r;
        speed  <= w.s;
        coding <= w.c;
        step(3);
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #(5000 * 50);
        failures++;
        $display("Error at %0t ns: watchdog expired", $time);
        summarize();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        step(1);
        chk({cont_en, shot_req, sw_trig, cfg_invalid, depth}, 32'h0000_0008, "in reset");
        repeat (2) @(posedge clk);
        nrst_n <= 1'b1;
        rchk(OFS_CONT, 32'h0000_0000);
        rchk(OFS_SHOT, 32'h0000_0000);
        rchk(OFS_VALID, 32'h0000_0000);
        rchk(OFS_DEPTH, {DEPTH_MONO8, 24'h00_0000});
        rchk(12'h0618, 32'h0000_0000);
        $display("test reset done");
        // sweep of the setting combinations
        for (int i = 0; i < 8; i++) begin
            set_cfg(rows[i]);
            chk({31'h0, cfg_invalid}, {31'h0, rows[i].bad}, "flag");
            chk({24'h0, depth}, {24'h0, rows[i].dep}, "depth");
            rchk(OFS_VALID, {rows[i].bad, 31'h0});
            rchk(OFS_DEPTH, {rows[i].dep, 24'h0});
        end
        host.put(OFS_VALID, 32'hFFFF_FFFF);
        host.put(OFS_DEPTH, 32'hFFFF_FFFF);
        rchk(OFS_VALID, 32'h0000_0000);
        rchk(OFS_DEPTH, {DEPTH_MONO8, 24'h00_0000});
        $display("test status done");
        // continuous transmission, reserved bits set as well
        host.put(OFS_CONT, 32'hFFFF_FFFF);
        step(2);
        chk({31'h0, cont_en}, 32'h0000_0001, "cont start");
        rchk(OFS_CONT, 32'h8000_0000);
        // single frame, then the unsupported fields
        host.put(OFS_SHOT, 32'h8000_0000);
        #1;
        chk({31'h0, shot_req}, 32'h0000_0001, "shot set");
        step(3);
        chk({31'h0, shot_req}, 32'h0000_0001, "shot held");
        @(posedge clk);
        frame_done <= 1'b1;
        @(posedge clk);
        frame_done <= 1'b0;
        #1;
        chk({31'h0, shot_req}, 32'h0000_0000, "shot cleared");
        rchk(OFS_SHOT, 32'h0000_0000);
        host.put(OFS_SHOT, 32'h7FFF_FFFF);
        step(2);
        chk({31'h0, shot_req}, 32'h0000_0000, "multi ignored");
        // unsupported format blocks capture and single frame
        set_cfg(rows[5]);
        chk({30'h0, cfg_invalid, cont_en}, 32'h0000_0002, "bad format");
        host.put(OFS_SHOT, 32'h8000_0000);
        step(2);
        chk({31'h0, shot_req}, 32'h0000_0000, "shot refused");
        set_cfg(rows[0]);
        host.put(OFS_CONT, 32'h0000_0000);
        step(2);
        chk({31'h0, cont_en}, 32'h0000_0000, "cont stop");
        $display("test transmit done");
        // software trigger: refused, self-clearing, then level mode
        host.put(OFS_TRIG, 32'h8000_0000);
        #1;
        chk({31'h0, sw_trig}, 32'h0000_0000, "trig refused");
        @(posedge clk);
        src_sw <= 1'b1;
        host.put(OFS_TRIG, 32'h8000_0000);
        #1;
        chk({31'h0, sw_trig}, 32'h0000_0001, "trig pulse");
        step(1);
        chk({31'h0, sw_trig}, 32'h0000_0000, "trig self clear");
        @(posedge clk);
        tmode <= 4'h1;
        host.put(OFS_TRIG, 32'h8000_0000);
        step(3);
        chk({31'h0, sw_trig}, 32'h0000_0001, "trig level");
        host.put(OFS_TRIG, 32'h0000_0000);
        #1;
        chk({31'h0, sw_trig}, 32'h0000_0000, "trig reset");
        $display("test trigger done");
        summarize();
    end
endmodule
